// *** system_config_control.sv ***
// System configuration bank: bus pin roles, clock output, segmentation,
// stack size and the end-of-init lock.
// Assumes straps are stable at reset release and inputs are synchronous.
//
// The strobed register port and the register offsets were decided locally.
`include "sys_cfg_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module system_config_control (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rstn,
  // Register port
  input  wire logic [`SYSCFG_ADDR_W-1:0]      reg_addr,
  input  wire logic [`SYSCFG_DATA_W-1:0]      reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [`SYSCFG_DATA_W-1:0]      reg_rdata,
  // Straps and core events
  input  wire logic                           write_config_sample_pin,
  input  wire logic                           bus_width_8,
  input  wire logic                           end_of_init_instruction,
  // External bus requests
  input  wire logic [`SYSCFG_EXT_ADDR_W-1:0]  bus_addr,
  input  wire logic                           bus_cycle_active,
  input  wire logic                           bus_write,
  input  wire logic                           bus_low_byte,
  input  wire logic                           bus_high_byte,
  // External bus pins
  output logic      [`SYSCFG_NUM_CS-1:0]      chip_select_n,
  output logic                              write_pin_n,
  output logic                              high_byte_enable_pin_n,
  output logic                              high_byte_enable_pin_oe_n,
  // Clock output port pin
  input  wire logic                           port_data_out,
  input  wire logic                           port_dir_out,
  output logic                              clock_out_port_pin,
  output logic                              clock_out_port_pin_oe_n,
  // Code address and stack frame
  input  wire logic [`SYSCFG_CSP_W-1:0]       code_segment_pointer,
  input  wire logic [`SYSCFG_IP_W-1:0]        instruction_pointer_reg,
  output logic      [`SYSCFG_EXT_ADDR_W-1:0]  code_fetch_addr,
  output logic                              push_code_segment,
  output logic      [`SYSCFG_FRAME_W-1:0]     stack_frame_words,
  output logic      [`SYSCFG_STK_WORDS_W-1:0] stack_size_words,
  // Mode levels for the core
  output logic                              segmentation_off,
  output logic                              config_locked
);

  // =====================================================
  // Helpers

  // Stack size in words from the field code
  function automatic logic [`SYSCFG_STK_WORDS_W-1:0] stack_words_of(
    input logic [`SYSCFG_STK_W-1:0] code
  );
    logic [`SYSCFG_STK_W-1:0] c;
    c = (code > `SYSCFG_STK_MAX_CODE) ? `SYSCFG_STK_MAX_CODE : code;
    return `SYSCFG_STK_MIN_WORDS << c;
  endfunction

  // Pack the configuration fields into a word
  function automatic logic [`SYSCFG_DATA_W-1:0] config_word(
    input sys_cfg_pkg::cfg_state_s s
  );
    logic [`SYSCFG_DATA_W-1:0] w;
    w = 16'h0000;
    w[`SYSCFG_BIT_CSMODE] = s.select_latch_mode;
    w[`SYSCFG_BIT_WRITE_STROBE_CONFIG]  = s.write_strobe_config;
    w[`SYSCFG_BIT_CLOCK_OUTPUT_ENABLE]  = s.clock_output_enable;
    w[`SYSCFG_BIT_HIGH_BYTE_PIN_DISABLE] = s.high_byte_pin_disable;
    w[`SYSCFG_BIT_SEGOFF] = s.segmentation_off;
    w[`SYSCFG_STK_MSB:`SYSCFG_STK_LSB] = s.stack_size_field;
    return w;
  endfunction

  // =====================================================
  // State

  sys_cfg_pkg::cfg_state_s          st;
  sys_cfg_pkg::cfg_state_s          next_st;
  logic [`SYSCFG_NUM_CS-1:0]        cs_comb_n;
  logic                             pending;
  logic                             cfg_write;

  // =====================================================
  // Chip-select decoder

  chip_select_decode #(
    .ADDR_W (`SYSCFG_EXT_ADDR_W),
    .NUM_CS (`SYSCFG_NUM_CS)
  ) u_cs_decode (
    .addr         (bus_addr),
    .cycle_active (bus_cycle_active),
    .cs_n         (cs_comb_n)
  );

  // Stored bus bits not yet in force
  assign pending = (st.act_unlatched != st.select_latch_mode) ||
                   (st.act_write_strobe_config != st.write_strobe_config) ||
                   (st.act_high_byte_pin_disable != st.high_byte_pin_disable);

  assign cfg_write = reg_wr && (reg_addr == `SYSCFG_OFS_CONFIG) && !st.locked;

  // =====================================================
  // Next state

  always_comb begin
    next_st = st;

    // Straps caught at the first edge after reset release
    if (!st.straps_loaded) begin
      next_st.straps_loaded = 1'b1;
      next_st.write_strobe_config = write_config_sample_pin;
      next_st.high_byte_pin_disable = bus_width_8;
    end

    // Software configuration write; reserved and foreign bits dropped
    if (cfg_write) begin
      next_st.select_latch_mode     = reg_wdata[`SYSCFG_BIT_CSMODE];
      next_st.write_strobe_config   = reg_wdata[`SYSCFG_BIT_WRITE_STROBE_CONFIG];
      next_st.clock_output_enable   = reg_wdata[`SYSCFG_BIT_CLOCK_OUTPUT_ENABLE];
      next_st.high_byte_pin_disable = reg_wdata[`SYSCFG_BIT_HIGH_BYTE_PIN_DISABLE];
      next_st.segmentation_off      = reg_wdata[`SYSCFG_BIT_SEGOFF];
      next_st.stack_size_field      = reg_wdata[`SYSCFG_STK_MSB:`SYSCFG_STK_LSB];
    end

    if (end_of_init_instruction) begin
      next_st.locked = 1'b1;
    end

    if (!bus_cycle_active) begin
      next_st.act_unlatched = st.select_latch_mode;
      next_st.act_write_strobe_config     = st.write_strobe_config;
      next_st.act_high_byte_pin_disable    = st.high_byte_pin_disable;
    end

    next_st.cs_latched_n = cs_comb_n;

    if (st.act_write_strobe_config) begin
      next_st.write_pin_n = !(bus_cycle_active && bus_write && bus_low_byte);
      next_st.bhe_pin_n   = !(bus_cycle_active && bus_write && bus_high_byte);
    end else begin
      next_st.write_pin_n = !(bus_cycle_active && bus_write);
      next_st.bhe_pin_n   = !(bus_cycle_active && bus_high_byte);
    end

    next_st.bhe_oe_n = st.act_high_byte_pin_disable;

    // Port pin as general I/O when the clock is off
    next_st.gpio_data = port_data_out;
    next_st.gpio_oe_n = !port_dir_out;

    if (st.segmentation_off) begin
      next_st.code_fetch_addr = {8'h00, instruction_pointer_reg};
    end else begin
      next_st.code_fetch_addr = {code_segment_pointer, instruction_pointer_reg};
    end

    next_st.push_csp    = !st.segmentation_off;
    next_st.frame_words = st.segmentation_off ? 2'h1 : 2'h2;

    next_st.stack_words = stack_words_of(st.stack_size_field);

    // Read data for the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `SYSCFG_OFS_CONFIG: begin
          next_st.rdata = config_word(st);
        end
        `SYSCFG_OFS_STATUS: begin
          next_st.rdata[`SYSCFG_BIT_LOCKED]  = st.locked;
          next_st.rdata[`SYSCFG_BIT_PENDING] = pending;
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  // =====================================================
  // State register

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st                       <= '0;
      st.select_latch_mode     <= `SYSCFG_RST_CSMODE;
      st.write_strobe_config   <= `SYSCFG_RST_WRITE_STROBE_CONFIG;
      st.clock_output_enable   <= `SYSCFG_RST_CLOCK_OUTPUT_ENABLE;
      st.high_byte_pin_disable <= `SYSCFG_RST_HIGH_BYTE_PIN_DISABLE;
      st.segmentation_off      <= `SYSCFG_RST_SEGOFF;
      st.stack_size_field      <= `SYSCFG_RST_STK;
      st.act_unlatched         <= `SYSCFG_RST_CSMODE;
      st.act_write_strobe_config             <= `SYSCFG_RST_WRITE_STROBE_CONFIG;
      st.act_high_byte_pin_disable            <= `SYSCFG_RST_HIGH_BYTE_PIN_DISABLE;
      st.cs_latched_n          <= {`SYSCFG_NUM_CS{1'b1}};
      st.write_pin_n           <= 1'b1;
      st.bhe_pin_n             <= 1'b1;
      st.bhe_oe_n              <= 1'b1;
      st.gpio_oe_n             <= 1'b1;
      st.push_csp              <= 1'b1;
      st.frame_words           <= 2'h2;
      st.stack_words           <= `SYSCFG_STK_MIN_WORDS;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================
  // Outputs

  assign chip_select_n = st.act_unlatched ? cs_comb_n : st.cs_latched_n;

  // Bus pins from the state register
  assign write_pin_n               = st.write_pin_n;
  assign high_byte_enable_pin_n    = st.bhe_pin_n;
  assign high_byte_enable_pin_oe_n = st.bhe_oe_n;

  assign clock_out_port_pin = st.clock_output_enable ? clk_sys : st.gpio_data;

  assign clock_out_port_pin_oe_n = st.clock_output_enable ? 1'b0 : st.gpio_oe_n;

  // Code address and stacking controls
  assign code_fetch_addr   = st.code_fetch_addr;
  assign push_code_segment = st.push_csp;
  assign stack_frame_words = st.frame_words;
  assign stack_size_words  = st.stack_words;

  // Mode levels and register read data
  assign segmentation_off = st.segmentation_off;
  assign config_locked    = st.locked;
  assign reg_rdata        = st.rdata;

endmodule // system_config_control

`default_nettype wire

// *** sys_cfg_regs.svh ***
// Offsets, field positions, reset values and widths of the configuration bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SYS_CFG_REGS_SVH
`define SYS_CFG_REGS_SVH

// =====================================================
// Register bus
`define SYSCFG_ADDR_W        4
`define SYSCFG_DATA_W        16
`define SYSCFG_OFS_CONFIG    4'h0
`define SYSCFG_OFS_STATUS    4'h1

// =====================================================
// Configuration word fields
`define SYSCFG_BIT_CSMODE    6
`define SYSCFG_BIT_WRITE_STROBE_CONFIG     7
`define SYSCFG_BIT_CLOCK_OUTPUT_ENABLE     8
`define SYSCFG_BIT_HIGH_BYTE_PIN_DISABLE    9
`define SYSCFG_BIT_SEGOFF    11
`define SYSCFG_BIT_ROMMAP    12
`define SYSCFG_STK_LSB       13
`define SYSCFG_STK_MSB       15
`define SYSCFG_STK_W         3

// =====================================================
// Status word fields
`define SYSCFG_BIT_LOCKED    0
`define SYSCFG_BIT_PENDING   1

// =====================================================
// Reset values
`define SYSCFG_RST_CSMODE    1'b0
`define SYSCFG_RST_WRITE_STROBE_CONFIG     1'b0
`define SYSCFG_RST_CLOCK_OUTPUT_ENABLE     1'b0
`define SYSCFG_RST_HIGH_BYTE_PIN_DISABLE    1'b0
`define SYSCFG_RST_SEGOFF    1'b0
`define SYSCFG_RST_STK       3'h0

// =====================================================
// External bus and stack
`define SYSCFG_EXT_ADDR_W    24
`define SYSCFG_IP_W          16
`define SYSCFG_CSP_W         8
`define SYSCFG_NUM_CS        4
`define SYSCFG_STK_WORDS_W   11
`define SYSCFG_STK_MIN_WORDS 11'h020
`define SYSCFG_STK_MAX_CODE  3'h5
`define SYSCFG_FRAME_W       2

`endif

// *** sys_cfg_pkg.sv ***
// Types for the configuration bank: the whole state of the top module.
// Assumes sys_cfg_regs.svh is on the include path.
`include "sys_cfg_regs.svh"

package sys_cfg_pkg;

  // =====================================================
  // Complete registered state
  typedef struct packed {
    logic                              select_latch_mode;
    logic                              write_strobe_config;
    logic                              clock_output_enable;
    logic                              high_byte_pin_disable;
    logic                              segmentation_off;
    logic [`SYSCFG_STK_W-1:0]          stack_size_field;
    logic                              act_unlatched;
    logic                              act_write_strobe_config;
    logic                              act_high_byte_pin_disable;
    logic                              locked;
    logic                              straps_loaded;
    logic [`SYSCFG_DATA_W-1:0]         rdata;
    logic [`SYSCFG_NUM_CS-1:0]         cs_latched_n;
    logic                              write_pin_n;
    logic                              bhe_pin_n;
    logic                              bhe_oe_n;
    logic                              gpio_data;
    logic                              gpio_oe_n;
    logic [`SYSCFG_EXT_ADDR_W-1:0]     code_fetch_addr;
    logic                              push_csp;
    logic [`SYSCFG_FRAME_W-1:0]        frame_words;
    logic [`SYSCFG_STK_WORDS_W-1:0]    stack_words;
  } cfg_state_s;

endpackage

// *** chip_select_decode.sv ***
// Address decoder for the chip-select lines, purely combinational.
// Assumes the address and cycle flag are stable for the whole bus cycle.
`timescale 1ns/1ns
`default_nettype none

module chip_select_decode #(
  parameter int ADDR_W = 24,
  parameter int NUM_CS = 4
) (
  // Current external address
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              cycle_active,
  // Decoded selects, active low
  output logic      [NUM_CS-1:0] cs_n
);

  localparam int SEL_W = $clog2(NUM_CS);

  // One region per select in the top address bits
  function automatic logic [NUM_CS-1:0] decode(
    input logic [ADDR_W-1:0] a,
    input logic              act
  );
    logic [NUM_CS-1:0] r;
    r = {NUM_CS{1'b1}};
    for (int i = 0; i < NUM_CS; i++) begin
      if (act && (a[ADDR_W-1 -: SEL_W] == SEL_W'(i))) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  // Selects follow the address directly
  always_comb begin
    cs_n = decode(addr, cycle_active);
  end

endmodule // chip_select_decode

`default_nettype wire

// *** sys_cfg_checker.sv ***
// Port assertions for the configuration bank.
// Assumes one clock domain; bound onto the top module at the foot.
`include "sys_cfg_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module sys_cfg_checker (
  // Clock, reset and register port
  input wire logic                           clk_sys,
  input wire logic                           rstn,
  input wire logic [`SYSCFG_ADDR_W-1:0]      reg_addr,
  input wire logic                           reg_rd,
  input wire logic [`SYSCFG_DATA_W-1:0]      reg_rdata,
  input wire logic                           end_of_init_instruction,
  // External bus and clock pin
  input wire logic [`SYSCFG_EXT_ADDR_W-1:0]  bus_addr,
  input wire logic                           bus_cycle_active,
  input wire logic [`SYSCFG_NUM_CS-1:0]      chip_select_n,
  input wire logic                           port_dir_out,
  input wire logic                           clock_out_port_pin,
  input wire logic                           clock_out_port_pin_oe_n,
  // Code address, frame and modes
  input wire logic [`SYSCFG_CSP_W-1:0]       code_segment_pointer,
  input wire logic [`SYSCFG_IP_W-1:0]        instruction_pointer_reg,
  input wire logic [`SYSCFG_EXT_ADDR_W-1:0]  code_fetch_addr,
  input wire logic                           push_code_segment,
  input wire logic [`SYSCFG_FRAME_W-1:0]     stack_frame_words,
  input wire logic                           segmentation_off,
  input wire logic                           config_locked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Select lines expected for an address
  function automatic logic [3:0] dec(input logic [23:0] a, input logic act);
    return act ? ~(4'h1 << a[23:22]) : 4'hf;
  endfunction

  // =====================================================
  // Assertions
  seg_addr_a: assert property ($past(rstn) && !segmentation_off && !$past(segmentation_off)
    |-> code_fetch_addr == {$past(code_segment_pointer), $past(instruction_pointer_reg)})
    else $error("segmented fetch address wrong");
  flat_addr_a: assert property (segmentation_off && $past(segmentation_off)
    |-> code_fetch_addr == {8'h00, $past(instruction_pointer_reg)}) else $error("flat address wrong");
  stack_frame_a: assert property ($past(rstn) && $stable(segmentation_off) |->
    push_code_segment == !segmentation_off && stack_frame_words == (segmentation_off ? 2'h1 : 2'h2))
    else $error("stack frame wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h1 |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  reserved_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0
    |-> (reg_rdata & 16'h143f) == 16'h0000) else $error("reserved bits read set");
  lock_sticky_a: assert property (end_of_init_instruction || config_locked |=> config_locked)
    else $error("lock lost");
  config_frozen_a: assert property (config_locked && $past(config_locked) |-> $stable(segmentation_off))
    else $error("locked config changed");
  chip_select_a: assert property ($past(rstn) |-> $onehot0(~chip_select_n) &&
    (chip_select_n == dec(bus_addr, bus_cycle_active) ||
     chip_select_n == dec($past(bus_addr), $past(bus_cycle_active)))) else $error("select wrong");
  clk_high_a: assert property (@(negedge clk_sys) !clock_out_port_pin_oe_n &&
    !port_dir_out && !$past(port_dir_out) |-> clock_out_port_pin) else $error("clock pin low");
endmodule // sys_cfg_checker

bind system_config_control sys_cfg_checker checker_i (.clk_sys, .rstn, .reg_addr, .reg_rd,
  .reg_rdata, .end_of_init_instruction, .bus_addr, .bus_cycle_active, .chip_select_n,
  .port_dir_out, .clock_out_port_pin, .clock_out_port_pin_oe_n, .code_segment_pointer,
  .instruction_pointer_reg, .code_fetch_addr, .push_code_segment, .stack_frame_words,
  .segmentation_off, .config_locked);
`default_nettype wire

// *** ext_bus_model.sv ***
// Memories and peripherals on the external bus, seen through their pins.
// Assumes the high byte pin has a pull-up when released.
`timescale 1ns/1ns
`default_nettype none

module ext_bus_model (
  // Pins from the bank
  input  wire logic [3:0] chip_select_n,
  input  wire logic       high_byte_enable_pin_n,
  input  wire logic       high_byte_enable_pin_oe_n,
  // Answering device, 4 for none, and high lane use
  output logic      [2:0] selected,
  output logic            high_lane
);
  // Device index from the select lines
  always_comb begin
    selected = 3'h4;
    for (int i = 0; i < 4; i++) begin
      if (!chip_select_n[i]) begin
        selected = 3'(i);
      end
    end
  end
  // Released pin is pulled high, so the lane reads idle
  assign high_lane = !high_byte_enable_pin_oe_n && !high_byte_enable_pin_n;
endmodule // ext_bus_model
`default_nettype wire

// *** system_config_control_bench.sv ***
// Self-checking bench for the configuration bank.
// Assumes the checker binds itself and the bus model sits on the pins.
`timescale 1ns/1ns
`default_nettype none

module system_config_control_bench;
  // =====================================================
  // Signals
  logic        clk_sys, rstn, reg_wr, reg_rd, write_config_sample_pin, bus_width_8;
  logic        end_of_init_instruction, bus_cycle_active, bus_write, bus_low_byte;
  logic        bus_high_byte, port_data_out, port_dir_out, write_pin_n, high_lane;
  logic        high_byte_enable_pin_n, high_byte_enable_pin_oe_n, clock_out_port_pin;
  logic        clock_out_port_pin_oe_n, push_code_segment, segmentation_off, config_locked;
  logic [3:0]  reg_addr, chip_select_n;
  logic [15:0] reg_wdata, reg_rdata, instruction_pointer_reg, w, d;
  logic [23:0] bus_addr, code_fetch_addr, a;
  logic [7:0]  code_segment_pointer;
  logic [1:0]  stack_frame_words;
  logic [10:0] stack_size_words;
  logic [2:0]  selected;
  logic [31:0] seed = 32'h8c36;
  int          errors = 0;
  int          comparisons = 0;

  system_config_control system_config_control_i (.clk_sys, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .write_config_sample_pin, .bus_width_8,
    .end_of_init_instruction, .bus_addr, .bus_cycle_active, .bus_write, .bus_low_byte,
    .bus_high_byte, .chip_select_n, .write_pin_n, .high_byte_enable_pin_n,
    .high_byte_enable_pin_oe_n, .port_data_out, .port_dir_out, .clock_out_port_pin,
    .clock_out_port_pin_oe_n, .code_segment_pointer, .instruction_pointer_reg,
    .code_fetch_addr, .push_code_segment, .stack_frame_words, .stack_size_words,
    .segmentation_off, .config_locked);
  ext_bus_model ext_bus_model_i (.chip_select_n, .high_byte_enable_pin_n,
    .high_byte_enable_pin_oe_n, .selected, .high_lane);

  // =====================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] idx(input logic [23:0] x);
    return {1'b0, x[23:22]};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    {reg_addr, reg_wdata, reg_wr} <= {ad, dt, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
    @(posedge clk_sys) #1;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] dt);
    {reg_addr, reg_rd} <= {ad, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 dt = reg_rdata;
    @(posedge clk_sys) #1;
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  // =====================================================
  // Scenarios
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, end_of_init_instruction, bus_addr} = '0;
    {bus_cycle_active, bus_write, bus_low_byte, bus_high_byte, port_data_out} = '0;
    {port_dir_out, code_segment_pointer, instruction_pointer_reg} = '0;
    {rstn, write_config_sample_pin, bus_width_8} = 3'b011;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // Reset values and straps
    rd(4'h0, d);
    chk(d, 16'h0280);
    chk({stack_size_words, push_code_segment, stack_frame_words}, {11'h020, 3'h6});
    // Every stack code with random fields and core pointers
    for (int i = 0; i < 8; i++) begin
      w = 16'(rnd());
      w[15:13] = 3'(i);
      w[12:11] = {1'b0, i[0]};
      {code_segment_pointer, instruction_pointer_reg} <= 24'(rnd());
      wr(4'h0, w);
      rd(4'h0, d);
      chk(d, w & 16'hebc0);
      chk(stack_size_words, 11'h020 << ((i > 5) ? 5 : i));
      chk(code_fetch_addr, {w[11] ? 8'h00 : code_segment_pointer, instruction_pointer_reg});
      chk({push_code_segment, stack_frame_words}, w[11] ? 3'h1 : 3'h6);
      chk(segmentation_off, w[11]);
    end
    // Clock pin, byte strobes and latched selects
    port_data_out <= 1'b1;
    wr(4'h0, 16'h0180);
    @(negedge clk_sys) #1 chk({clock_out_port_pin, clock_out_port_pin_oe_n}, 2'b00);
    @(posedge clk_sys) #1 chk(clock_out_port_pin, 1'b1);
    a = 24'(rnd());
    {bus_addr, bus_cycle_active, bus_write, bus_high_byte} <= {a, 3'b111};
    repeat (2) @(posedge clk_sys);
    #1 chk({write_pin_n, high_byte_enable_pin_n, high_lane, selected}, {3'b101, idx(a)});
    bus_addr <= a ^ 24'hc00000;
    bus_low_byte <= 1'b1;
    #1 chk(selected, idx(a));
    @(posedge clk_sys) #1 chk(selected, idx(a ^ 24'hc00000));
    chk(write_pin_n, 1'b0);
    // Unlatched selects, normal write pin, high byte pin freed
    bus_cycle_active <= 1'b0;
    wr(4'h0, 16'h0240);
    chk({clock_out_port_pin, clock_out_port_pin_oe_n}, 2'b11);
    a = a ^ 24'h800000;
    {bus_addr, bus_cycle_active} <= {a, 1'b1};
    #1 chk(selected, idx(a));
    @(posedge clk_sys) #1 chk({write_pin_n, high_byte_enable_pin_oe_n, high_lane}, 3'b010);
    // Change held back during a bus cycle, refused accesses
    wr(4'h0, 16'h0000);
    rd(4'h1, d);
    chk(d, 16'h0002);
    bus_cycle_active <= 1'b0;
    wr(4'h1, 16'hffff);
    rd(4'h7, d);
    chk(d, 16'h0000);
    rd(4'h1, d);
    chk(d, 16'h0000);
    // Lock after end of init, then cleared by reset
    end_of_init_instruction <= 1'b1;
    @(posedge clk_sys) end_of_init_instruction <= 1'b0;
    wr(4'h0, 16'h0800);
    rd(4'h0, d);
    chk(d, 16'h0000);
    rd(4'h1, d);
    chk(d, 16'h0001);
    chk(config_locked, 1'b1);
    {rstn, write_config_sample_pin, bus_width_8} <= 3'b000;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(4'h1, d);
    chk(d, 16'h0000);
    chk(config_locked, 1'b0);
    rd(4'h0, d);
    chk(d, 16'h0000);
    end_sim();
  end
endmodule // system_config_control_bench
`default_nettype wire
